/* File: logic/drfd_pkg.sv */
package drfd_pkg;

  // ----------------------------------------------------------------
  // Sizes and codes
  // ----------------------------------------------------------------
  localparam int         ADDR_W      = 14;
  localparam int         ROW_LEN     = 80;
  localparam logic [6:0] ROW_TC      = 7'h50;
  localparam logic [6:0] COL_LAST    = 7'h4f;
  localparam logic [7:0] BLANK_CHAR  = 8'h20;
  localparam logic [7:0] LINE_END    = 8'hcc;
  localparam logic [7:0] PAGE_END    = 8'hce;
  localparam logic [13:0] ADDR_CLEAR = 14'h0000;
  localparam int         INV_BIT     = 1;
  localparam int         LINK_HI_W   = 6;
  localparam int         FIFO_DEPTH  = 8;

  // ----------------------------------------------------------------
  // Bus sequencer states and byte classes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SEQ_IDLE,
    SEQ_BID,
    SEQ_OBTAINED,
    SEQ_REQUEST,
    SEQ_WAIT,
    SEQ_RELEASE
  } drfd_seq_t;

  typedef enum logic [2:0] {
    CLS_CONTROL,
    CLS_CHAR,
    CLS_PAGE_END,
    CLS_LINE_END,
    CLS_LINK
  } drfd_cls_t;

  // One row buffer write, queued between the fetch side and the buffers.
  typedef struct packed {
    logic       bufSel;
    logic [6:0] col;
    logic       inv;
    logic [6:0] code;
  } drfd_entry_t;

  localparam int ENTRY_W = $bits(drfd_entry_t);

endpackage

/* File: logic/drfd_fetch.sv */
`timescale 1ns/1ps

// --------------------------------------------------------------------
// Write queue between the fetch side and the row buffers
// --------------------------------------------------------------------
module drfd_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic [WIDTH-1:0]      outData
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW:0]      wrPtr_q;
  logic [PW:0]      rdPtr_q;
  logic             full;
  logic             empty;

  // Extra pointer bit tells full from empty.
  assign empty    = (wrPtr_q == rdPtr_q);
  assign full     = (wrPtr_q[PW-1:0] == rdPtr_q[PW-1:0]) && (wrPtr_q[PW] != rdPtr_q[PW]);
  assign inReady  = !full;
  assign outValid = !empty;
  assign outData  = mem[rdPtr_q[PW-1:0]];

  // Storage write.
  always_ff @(posedge clk) begin
    if (inValid && !full) begin
      mem[wrPtr_q[PW-1:0]] <= inData;
    end
  end

  // Pointer update.
  always_ff @(posedge clk) begin
    if (rst) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
    end else begin
      if (inValid && !full) begin
        wrPtr_q <= wrPtr_q + 1'b1;
      end
      if (outReady && !empty) begin
        rdPtr_q <= rdPtr_q + 1'b1;
      end
    end
  end
endmodule

// Functional notes
// - Two row buffers; fill one, display other.
// - Link byte fetches one more address byte.
// - Line end blanks rest of row.
// - Page end blanks rest of page.
// - Control byte bit one is inverse video.
// - Characters are 7-bit codes, 128 glyphs.
// - Row start pulse clears character counter.
// - Each character load increments the counter.
// - Count 80 holds sequencer idle.
// - 14-bit down counting address drives bus.
// - Link load: held byte high, bus low.
// - Frame sync clears address counter.
// - Line/page end stop address counting.
// - Address outputs released except when commanded.
// - 8-bit holding register captures bus data.
// - Fill mode pseudo reads load blanks.
// - Control sets flags, characters enter buffer.
// - Reset clears the holding register.
// - Priority decode gives exactly one class.
// - Holding register captured entering wait state.
// - Character load pulse in release state.
// - Sequencer walks idle-bid-obtained-request-wait-release.
// - Fill blank is code 040 octal.
// - Counter end clears line flag; sync clears page.
// - Byte classes from upper bit prefixes.
module drfd_fetch (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        rowStartPulse,
  input  wire logic        frameSyncPulse,
  input  wire logic        evenRowSel,
  input  wire logic        dmaEnable,
  input  wire logic        busPriorIn,
  input  wire logic        busWait,
  input  wire logic [7:0]  busData,
  input  wire logic        dispShift,
  output logic             busPriorOut,
  output logic             busBusy,
  output logic             busReq,
  output logic [13:0]      addrBus,
  output logic             addrDriveN,
  output logic [7:0]       dispChar,
  output logic             inverseVideo,
  output logic [6:0]       charCount
);

  // ------------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------------
  drfd_pkg::drfd_seq_t   state_q;
  drfd_pkg::drfd_seq_t   state_d;
  drfd_pkg::drfd_cls_t   cls;
  drfd_pkg::drfd_entry_t pushEntry;
  drfd_pkg::drfd_entry_t popEntry;
  logic [7:0]  hold_q;
  logic [7:0]  lowByte_q;
  logic [13:0] addr_q;
  logic [6:0]  count_q;
  logic [6:0]  dispCol_q;
  logic        lineEnd_q;
  logic        pageEnd_q;
  logic        linkPend_q;
  logic        inv_q;
  logic        busPriorOut_q;
  logic        busBusy_q;
  logic        busReq_q;
  logic        addrDriveN_q;
  logic [7:0]  dispChar_q;
  logic        fill;
  logic        enterWait;
  logic        inRelease;
  logic        loadPulse;
  logic        fifoInReady;
  logic        fifoOutValid;
  logic        fifoOutReady;
  logic [drfd_pkg::ENTRY_W-1:0] popBits;
  logic [7:0]  rowMem [2][drfd_pkg::ROW_LEN];

  // ------------------------------------------------------------------
  // Byte classifier
  // ------------------------------------------------------------------

  // Priority decode on the highest set prefix; flags fall in with control.
  function automatic drfd_pkg::drfd_cls_t classify(input logic [7:0] b);
    drfd_pkg::drfd_cls_t c;
    c = drfd_pkg::CLS_CONTROL;
    if (!b[7]) begin
      c = drfd_pkg::CLS_CHAR;
    end else if (!b[6]) begin
      c = drfd_pkg::CLS_CONTROL;
    end else if (b[5] || b[4]) begin
      c = drfd_pkg::CLS_LINK;
    end else if (b == drfd_pkg::LINE_END) begin
      c = drfd_pkg::CLS_LINE_END;
    end else if (b == drfd_pkg::PAGE_END) begin
      c = drfd_pkg::CLS_PAGE_END;
    end
    return c;
  endfunction

  // Decode of the held byte, one class at a time.
  assign cls       = classify(hold_q);
  assign fill      = lineEnd_q || pageEnd_q;
  assign enterWait = (state_q == drfd_pkg::SEQ_REQUEST) && (state_d == drfd_pkg::SEQ_WAIT);
  assign inRelease = (state_q == drfd_pkg::SEQ_RELEASE);
  assign loadPulse = inRelease && !linkPend_q && (cls == drfd_pkg::CLS_CHAR)
                     && (count_q < drfd_pkg::ROW_TC);

  // ------------------------------------------------------------------
  // Bus sequencer
  // ------------------------------------------------------------------

  // Next state; idle waits for room in the row, enable and queue space.
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      drfd_pkg::SEQ_IDLE: begin
        if (dmaEnable && fifoInReady && !rowStartPulse && (count_q < drfd_pkg::ROW_TC)) begin
          state_d = drfd_pkg::SEQ_BID;
        end
      end
      drfd_pkg::SEQ_BID: begin
        if (busPriorIn) begin
          state_d = drfd_pkg::SEQ_OBTAINED;
        end
      end
      drfd_pkg::SEQ_OBTAINED: begin
        state_d = drfd_pkg::SEQ_REQUEST;
      end
      drfd_pkg::SEQ_REQUEST: begin
        if (busWait || fill) begin
          state_d = drfd_pkg::SEQ_WAIT;
        end
      end
      drfd_pkg::SEQ_WAIT: begin
        state_d = drfd_pkg::SEQ_RELEASE;
      end
      drfd_pkg::SEQ_RELEASE: begin
        state_d = drfd_pkg::SEQ_IDLE;
      end
    endcase
  end

  // State register.
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= drfd_pkg::SEQ_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Registered bus controls, derived from the next state.
  always_ff @(posedge clk) begin
    if (rst) begin
      busPriorOut_q <= 1'b0;
      busBusy_q     <= 1'b0;
      busReq_q      <= 1'b0;
      addrDriveN_q  <= 1'b1;
    end else begin
      busPriorOut_q <= (state_d == drfd_pkg::SEQ_BID) || (state_d == drfd_pkg::SEQ_OBTAINED)
                       || (state_d == drfd_pkg::SEQ_REQUEST);
      busBusy_q     <= (state_d == drfd_pkg::SEQ_OBTAINED) || (state_d == drfd_pkg::SEQ_REQUEST)
                       || (state_d == drfd_pkg::SEQ_WAIT);
      busReq_q      <= (state_d == drfd_pkg::SEQ_REQUEST) && !fill;
      addrDriveN_q  <= !((state_d == drfd_pkg::SEQ_OBTAINED) || (state_d == drfd_pkg::SEQ_REQUEST)
                       || (state_d == drfd_pkg::SEQ_WAIT));
    end
  end

  // ------------------------------------------------------------------
  // Holding register and link low byte
  // ------------------------------------------------------------------

  // Capture on entry to wait; a pending link keeps the high byte held.
  always_ff @(posedge clk) begin
    if (rst) begin
      hold_q    <= 8'h00;
      lowByte_q <= 8'h00;
    end else if (enterWait) begin
      if (linkPend_q) begin
        lowByte_q <= busData;
      end else if (fill) begin
        hold_q <= drfd_pkg::BLANK_CHAR;
      end else begin
        hold_q <= busData;
      end
    end
  end

  // ------------------------------------------------------------------
  // Address counter
  // ------------------------------------------------------------------

  // Sync clears, link loads both halves, normal reads count down.
  always_ff @(posedge clk) begin
    if (rst) begin
      addr_q <= drfd_pkg::ADDR_CLEAR;
    end else if (frameSyncPulse) begin
      addr_q <= drfd_pkg::ADDR_CLEAR;
    end else if (inRelease && linkPend_q) begin
      addr_q <= {hold_q[drfd_pkg::LINK_HI_W-1:0], lowByte_q};
    end else if (inRelease && !fill) begin
      addr_q <= addr_q - 14'h0001;
    end
  end

  // ------------------------------------------------------------------
  // Control flags
  // ------------------------------------------------------------------

  // Link pending flag: set by a link byte, cleared after the address load.
  always_ff @(posedge clk) begin
    if (rst) begin
      linkPend_q <= 1'b0;
    end else if (inRelease) begin
      linkPend_q <= !linkPend_q && (cls == drfd_pkg::CLS_LINK);
    end
  end

  // Line end flag: set wins over the terminal count clear.
  always_ff @(posedge clk) begin
    if (rst) begin
      lineEnd_q <= 1'b0;
    end else if (inRelease && !linkPend_q && (cls == drfd_pkg::CLS_LINE_END)) begin
      lineEnd_q <= 1'b1;
    end else if (count_q == drfd_pkg::ROW_TC) begin
      lineEnd_q <= 1'b0;
    end
  end

  // Page end flag: set wins over the frame sync clear.
  always_ff @(posedge clk) begin
    if (rst) begin
      pageEnd_q <= 1'b0;
    end else if (inRelease && !linkPend_q && (cls == drfd_pkg::CLS_PAGE_END)) begin
      pageEnd_q <= 1'b1;
    end else if (frameSyncPulse) begin
      pageEnd_q <= 1'b0;
    end
  end

  // Inverse video: taken from bit one of a control byte, cleared in fill.
  always_ff @(posedge clk) begin
    if (rst) begin
      inv_q <= 1'b0;
    end else if (inRelease && fill) begin
      inv_q <= 1'b0;
    end else if (inRelease && !linkPend_q && (cls == drfd_pkg::CLS_CONTROL) && !hold_q[6]) begin
      inv_q <= hold_q[drfd_pkg::INV_BIT];
    end
  end

  // ------------------------------------------------------------------
  // Character counter
  // ------------------------------------------------------------------

  // Cleared at row start, advanced by each load, never past 80.
  always_ff @(posedge clk) begin
    if (rst) begin
      count_q <= 7'h00;
    end else if (rowStartPulse) begin
      count_q <= 7'h00;
    end else if (loadPulse) begin
      count_q <= count_q + 7'h01;
    end
  end

  // ------------------------------------------------------------------
  // Write queue and row buffers
  // ------------------------------------------------------------------

  // Each load queues the character for the buffer named by the row select.
  // A fill blank never carries inverse video, since the entry masks the flag with fill.
  always_comb begin
    pushEntry        = '0;
    pushEntry.bufSel = evenRowSel;
    pushEntry.col    = count_q;
    pushEntry.inv    = inv_q && !fill;
    pushEntry.code   = hold_q[6:0];
  end

  drfd_fifo #(
    .WIDTH (drfd_pkg::ENTRY_W),
    .DEPTH (drfd_pkg::FIFO_DEPTH)
  ) uFifo (
    .clk      (clk),
    .rst      (rst),
    .inValid  (loadPulse),
    .inReady  (fifoInReady),
    .inData   (pushEntry),
    .outValid (fifoOutValid),
    .outReady (fifoOutReady),
    .outData  (popBits)
  );

  // Buffer port is shared with display reads, so a shift stalls the drain.
  assign fifoOutReady = !dispShift;
  assign popEntry     = drfd_pkg::drfd_entry_t'(popBits);

  // Row buffer write.
  always_ff @(posedge clk) begin
    if (fifoOutValid && fifoOutReady) begin
      rowMem[popEntry.bufSel][popEntry.col] <= {popEntry.inv, popEntry.code};
    end
  end

  // Display side rotates the other buffer, once per scan line.
  always_ff @(posedge clk) begin
    if (rst) begin
      dispCol_q  <= 7'h00;
      dispChar_q <= 8'h00;
    end else if (rowStartPulse) begin
      dispCol_q <= 7'h00;
    end else if (dispShift) begin
      dispChar_q <= rowMem[!evenRowSel][dispCol_q];
      dispCol_q  <= (dispCol_q == drfd_pkg::COL_LAST) ? 7'h00 : dispCol_q + 7'h01;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  assign busPriorOut  = busPriorOut_q;
  assign busBusy      = busBusy_q;
  assign busReq       = busReq_q;
  assign addrBus      = addr_q;
  assign addrDriveN   = addrDriveN_q;
  assign dispChar     = dispChar_q;
  assign inverseVideo = inv_q;
  assign charCount    = count_q;

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_row_clear;
    rowStartPulse |=> (count_q == 7'h00);
  endproperty
  a_row_clear: assert property (p_row_clear) else $error("row start did not clear count");

  property p_count_max;
    count_q <= drfd_pkg::ROW_TC;
  endproperty
  a_count_max: assert property (p_count_max) else $error("count passed 80");

  property p_hold_idle;
    (count_q == drfd_pkg::ROW_TC) && !rowStartPulse && (state_q == drfd_pkg::SEQ_IDLE)
      |=> (state_q == drfd_pkg::SEQ_IDLE);
  endproperty
  a_hold_idle: assert property (p_hold_idle) else $error("sequencer left idle at count 80");

  property p_load_count;
    loadPulse && !rowStartPulse |=> (count_q == $past(count_q) + 7'h01);
  endproperty
  a_load_count: assert property (p_load_count) else $error("load did not advance count");

  property p_sync_addr;
    frameSyncPulse && !inRelease |=> (addr_q == drfd_pkg::ADDR_CLEAR) && !pageEnd_q;
  endproperty
  a_sync_addr: assert property (p_sync_addr) else $error("frame sync did not clear");

  property p_fill_blank;
    enterWait && fill && !linkPend_q |=> (hold_q == drfd_pkg::BLANK_CHAR) && !busReq_q;
  endproperty
  a_fill_blank: assert property (p_fill_blank) else $error("fill read not blank");

  property p_capture;
    enterWait && !fill && !linkPend_q |=> (hold_q == $past(busData));
  endproperty
  a_capture: assert property (p_capture) else $error("bus byte not captured");

  property p_link_load;
    inRelease && linkPend_q && !frameSyncPulse
      |=> (addr_q == {$past(hold_q[5:0]), $past(lowByte_q)}) && !linkPend_q;
  endproperty
  a_link_load: assert property (p_link_load) else $error("link address not loaded");

  property p_count_down;
    inRelease && !linkPend_q && !fill && !frameSyncPulse |=> (addr_q == $past(addr_q) - 14'h0001);
  endproperty
  a_count_down: assert property (p_count_down) else $error("address did not count down");

  property p_inhibit;
    inRelease && fill && !frameSyncPulse && !linkPend_q |=> $stable(addr_q);
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("address moved during fill");

  property p_drive;
    (state_q == drfd_pkg::SEQ_IDLE) || (state_q == drfd_pkg::SEQ_BID) |-> addrDriveN_q;
  endproperty
  a_drive: assert property (p_drive) else $error("address driven outside ownership");

  property p_walk;
    (state_q == drfd_pkg::SEQ_WAIT) |=> (state_q == drfd_pkg::SEQ_RELEASE) ##1 (state_q == drfd_pkg::SEQ_IDLE);
  endproperty
  a_walk: assert property (p_walk) else $error("sequencer order broken");

  property p_eol_clear;
    lineEnd_q && (count_q == drfd_pkg::ROW_TC) && !inRelease |=> !lineEnd_q;
  endproperty
  a_eol_clear: assert property (p_eol_clear) else $error("line flag not cleared");

  c_char_load: cover property (loadPulse);
  c_link: cover property (inRelease && linkPend_q);
  c_line_fill: cover property (lineEnd_q && loadPulse);
  c_full_row: cover property (count_q == drfd_pkg::ROW_TC);

endmodule

/* File: sim/drfd_mem_model.sv */
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Terminal memory on the far side of the shared bus
// ----------------------------------------------------------------
module drfd_mem_model (
  input  wire logic        clk,
  input  wire logic        busPriorOut,
  input  wire logic        busReq,
  input  wire logic [13:0] addrBus,
  output logic             busPriorIn,
  output logic             busWait,
  output logic [7:0]       busData
);
  logic [7:0]  mem [0:16383];
  logic [13:0] seen [$];
  int          lag;
  int          grantCnt;
  int          readCnt;

  // The bench sets lag to make the partner answer slowly.
  initial begin
    busPriorIn = 1'b0;
    busWait    = 1'b0;
    busData    = 8'h5a;
    lag        = 0;
    grantCnt   = 0;
    readCnt    = 0;
  end

  // Grant after lag cycles of bidding, answer a request after lag cycles.
  // Undriven data toggles every cycle so a stale value is never mistaken for a read.
  always @(negedge clk) begin
    grantCnt   <= (busPriorOut === 1'b1) ? grantCnt + 1 : 0;
    busPriorIn <= (busPriorOut === 1'b1) && (grantCnt >= lag);
    if (busReq === 1'b1) begin
      readCnt <= readCnt + 1;
      if (readCnt >= lag) begin
        busWait <= 1'b1;
        busData <= mem[~addrBus];
      end
    end else begin
      readCnt <= 0;
      busWait <= 1'b0;
      busData <= ~busData;
    end
  end

  // Every completed real read logs the raw address it used.
  always @(posedge clk) begin
    if (busReq === 1'b1 && busWait === 1'b1) seen.push_back(addrBus);
  end
endmodule

/* File: sim/tb_drfd_fetch.sv */
`timescale 1ns/1ps

module tb_drfd_fetch;
  logic clk, rst, rowStartPulse, frameSyncPulse, evenRowSel, dmaEnable, busPriorIn, busWait, dispShift;
  logic busPriorOut, busBusy, busReq, addrDriveN, inverseVideo;
  logic [7:0]  busData, dispChar;
  logic [13:0] addrBus, rawPtr;
  logic [6:0]  charCount;
  logic        inv;
  logic [7:0]  expRow [0:5][0:79];
  logic [13:0] expAddr [$];
  int          fail_count, comparisons, curRow, col;

  drfd_fetch u_drfd_fetch (.clk(clk), .rst(rst), .rowStartPulse(rowStartPulse), .frameSyncPulse(frameSyncPulse),
    .evenRowSel(evenRowSel), .dmaEnable(dmaEnable), .busPriorIn(busPriorIn), .busWait(busWait), .busData(busData),
    .dispShift(dispShift), .busPriorOut(busPriorOut), .busBusy(busBusy), .busReq(busReq), .addrBus(addrBus),
    .addrDriveN(addrDriveN), .dispChar(dispChar), .inverseVideo(inverseVideo), .charCount(charCount));
  drfd_mem_model u_drfd_mem_model (.clk(clk), .busPriorOut(busPriorOut), .busReq(busReq), .addrBus(addrBus),
    .busPriorIn(busPriorIn), .busWait(busWait), .busData(busData));

  // Clock at 250 MHz.
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Shared helpers
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] expv);
    comparisons++;
    if (seen !== expv) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, expv, seen);
    end
  endtask

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Store one byte at the next fetch position and note the raw address expected on the bus.
  task automatic put(input logic [7:0] b);
    u_drfd_mem_model.mem[~rawPtr] = b;
    expAddr.push_back(rawPtr);
    rawPtr = rawPtr - 14'h0001;
  endtask

  task automatic ch(input logic [6:0] c);
    put({1'b0, c});
    expRow[curRow][col] = {inv, c};
    col++;
  endtask

  task automatic ctl(input logic [7:0] b);
    put(b);
    inv = b[1];
  endtask

  task automatic link(input logic [7:0] hi, input logic [7:0] lo);
    put(hi);
    put(lo);
    rawPtr = {hi[5:0], lo};
  endtask

  task automatic fillBlank();
    inv = 1'b0;
    while (col < 80) begin
      expRow[curRow][col] = 8'h20;
      col++;
    end
  endtask

  // Memory image: a full row with controls, flags and both link forms, a line end, a page end.
  task automatic build();
    int i;
    int n0;
    rawPtr = 14'h0000;
    curRow = 0;
    col = 0;
    inv = 1'b0;
    for (i = 0; i < 80; i++) begin
      if (i == 10) ctl(8'h82);
      if (i == 15) put(8'hc8);
      if (i == 20) ctl(8'h80);
      if (i == 30) put(8'hc3);
      if (i == 50) link(8'he5, 8'h34);
      if (i == 60) link(8'hd2, 8'h00);
      ch(i == 40 ? 7'h7f : (i == 41 ? 7'h00 : 7'h21 + 7'(i)));
    end
    n0 = expAddr.size();
    curRow = 1;
    col = 0;
    ctl(8'h82);
    for (i = 0; i < 5; i++) ch(7'h41 + 7'(i));
    put(8'hcc);
    fillBlank();
    curRow = 2;
    col = 0;
    for (i = 0; i < 3; i++) ch(7'h61 + 7'(i));
    put(8'hce);
    fillBlank();
    curRow = 3;
    col = 0;
    fillBlank();
    for (i = 0; i < n0; i++) expAddr.push_back(expAddr[i]);
    expRow[4] = expRow[0];
  endtask

  task automatic syncPulse();
    @(negedge clk);
    frameSyncPulse = 1'b1;
    @(negedge clk);
    frameSyncPulse = 1'b0;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic checkReset();
    check("idleOutputs", 16'({addrDriveN, busReq, busPriorOut, busBusy}), 16'h0008);
    check("addrBus", 16'(addrBus), 16'h0000);
    check("dispChar", 16'(dispChar), 16'h0000);
    check("charCount", 16'(charCount), 16'h0000);
  endtask

  // Shifting blocks the queue drain: fetching must stop idle once the queue holds eight loads.
  task automatic fifoTest();
    dispShift = 1'b1;
    repeat (200) @(negedge clk);
    check("stallCount", 16'(charCount), 16'(drfd_pkg::FIFO_DEPTH));
    check("stallPrior", 16'(busPriorOut), 16'h0000);
    check("stallBusy", 16'(busBusy), 16'h0000);
    check("stallReq", 16'(busReq), 16'h0000);
    check("stallDrive", 16'(addrDriveN), 16'h0001);
    dispShift = 1'b0;
  endtask

  // Start a row, show the previously filled buffer, then wait for this fill to end.
  task automatic doRow(input int k, input logic sel, input bit fetch, input bit stall);
    int t;
    @(negedge clk);
    evenRowSel = sel;
    rowStartPulse = 1'b1;
    @(negedge clk);
    rowStartPulse = 1'b0;
    check("charCount", 16'(charCount), 16'h0000);
    if (stall) fifoTest();
    if (k > 0) begin
      dispShift = 1'b1;
      for (t = 0; t < 80; t++) begin
        @(negedge clk);
        if (t == 79) dispShift = 1'b0;
        check("dispChar", 16'(dispChar), 16'(expRow[k-1][t]));
      end
    end
    t = 0;
    while (fetch && charCount !== 7'h50 && t < 4000) begin
      @(negedge clk);
      t++;
    end
    if (t >= 4000) check("fillTimeout", 16'h0001, 16'h0000);
    repeat (20) begin
      @(negedge clk);
      check("busPriorOut", 16'(busPriorOut), 16'h0000);
      if (fetch) check("charCount", 16'(charCount), 16'h0050);
    end
  endtask

  task automatic checkAddrLog();
    int i;
    check("readCount", 16'(u_drfd_mem_model.seen.size()), 16'(expAddr.size()));
    for (i = 0; i < expAddr.size() && i < u_drfd_mem_model.seen.size(); i++)
      check("addrBus", 16'(u_drfd_mem_model.seen[i]), 16'(expAddr[i]));
  endtask

  // Address drive follows the bus phases, and a request only stands while the bus is held.
  always @(negedge clk) begin
    if (rst === 1'b0) begin
      check("addrDriveN", 16'(addrDriveN), 16'(!busBusy));
      if (busReq === 1'b1) check("requestPhase", 16'(busPriorOut & busBusy), 16'h0001);
    end
  end

  // Watchdog far beyond the expected run of some 3500 cycles.
  initial begin
    #200000;
    fail_count++;
    conclude();
  end

  // Main sequence.
  initial begin
    {rowStartPulse, frameSyncPulse, evenRowSel, dmaEnable, dispShift} = 5'h00;
    fail_count = 0;
    comparisons = 0;
    rst = 1'b1;
    build();
    repeat (8) @(negedge clk);
    rst = 1'b0;
    checkReset();
    syncPulse();
    dmaEnable = 1'b1;
    doRow(0, 1'b1, 1'b1, 1'b1);
    doRow(1, 1'b0, 1'b1, 1'b0);
    doRow(2, 1'b1, 1'b1, 1'b0);
    doRow(3, 1'b0, 1'b1, 1'b0);
    syncPulse();
    u_drfd_mem_model.lag = 2;
    doRow(4, 1'b1, 1'b1, 1'b0);
    dmaEnable = 1'b0;
    doRow(5, 1'b0, 1'b0, 1'b0);
    checkAddrLog();
    conclude();
  end
endmodule
